/* hdl/dso_status_out.v */
// Overview of operation
// - terminal or relay selecting function 11 shows the run-time-over status.
// - terminal or relay selecting function 12 shows power-on-time-over, same warning time.
// - time-over status asserts once accumulated hours exceed the warning time.
// - warning time 0 disables both; otherwise units of 10 or 100 hours.
// - zero-speed asserts while monitored frequency is below the detection level.
// - terminal or relay selecting function 21 shows the zero-speed status.
// - zero-speed uses output frequency, or motor speed under sensor vector control.
// - terminal selecting function 07 shows over-torque when torque exceeds threshold.
// - over-torque threshold picked from four by operating quadrant.
// - over-torque meaningful only in the three vector modes; held low otherwise.
// - trip code mode 00 none, 01 three-bit code, 02 four-bit code.
// - code modes force terminals 11-13 or 11-14, terminal 11 least significant.
// - codes 0 normal, 1..6 for the six basic trip causes.
// - code 7 braking resistor overload in 4-bit mode, all others in 3-bit.
// - 4-bit code 8 internal faults, code 9 current transducer error.
// - 4-bit code 10 external/start/thermistor/braking, code 11 ground fault.
// - 4-bit codes 12 sequence, 13 fan temperature, 14 phase loss, 15 user.
`timescale 1ns/10ps
`include "dso_status_consts.vh"

module dso_status_out #(
   parameter HOUR_W  = 20,   // accumulated hour counters
   parameter FREQ_W  = 16,   // frequency in 0.01 Hz steps
   parameter TORQ_W  = 8,    // torque magnitude in percent
   parameter N_TERM  = 5     // intelligent output terminals
) (
   input  wire                  core_clk,
   input  wire                  reset_n,
   input  wire [HOUR_W-1:0]     run_hours,
   input  wire [HOUR_W-1:0]     power_on_hours,
   input  wire [13:0]           warning_time_setting,
   input  wire                  warning_time_unit_100h,
   input  wire [2:0]            control_curve_select,
   input  wire [FREQ_W-1:0]     output_freq,
   input  wire [FREQ_W-1:0]     motor_speed,
   input  wire [FREQ_W-1:0]     zero_speed_level,
   input  wire [TORQ_W-1:0]     torque_est,
   input  wire                  torque_reverse,
   input  wire                  torque_regen,
   input  wire [TORQ_W-1:0]     torque_limit_fwd_drive,
   input  wire [TORQ_W-1:0]     torque_limit_rev_regen,
   input  wire [TORQ_W-1:0]     torque_limit_rev_drive,
   input  wire [TORQ_W-1:0]     torque_limit_fwd_regen,
   input  wire [1:0]            trip_code_mode,
   input  wire [6:0]            trip_cause,
   input  wire [6*N_TERM-1:0]   output_terminal_function_select,
   input  wire [5:0]            alarm_relay_function_select,
   output reg                   run_time_over,
   output reg                   power_on_time_over,
   output reg                   zero_speed_detect,
   output reg                   over_torque_flag,
   output reg  [3:0]            trip_code,
   output wire                  trip_code_bit0,
   output wire                  trip_code_bit1,
   output wire                  trip_code_bit2,
   output wire                  trip_code_bit3,
   output reg  [N_TERM-1:0]     terminal_out,
   output reg                   alarm_relay_out
);

   // time-over path
   wire [23:0]       warn_unit;
   wire [23:0]       warn_hours;
   wire [23:0]       run_hours_ext;
   wire [23:0]       pon_hours_ext;
   wire              warn_enabled;
   wire              run_over_nxt;
   wire              pon_over_nxt;

   // zero-speed and over-torque path
   reg  [FREQ_W-1:0] zs_source;
   wire              zs_nxt;
   wire [1:0]        quadrant;
   reg  [TORQ_W-1:0] torque_thresh;
   reg               vector_mode;
   wire              otq_nxt;

   // trip code and terminal path
   reg  [3:0]        code4;
   reg  [3:0]        code3;
   reg  [3:0]        trip_code_nxt;
   wire [N_TERM-1:0] terminal_nxt;
   reg               alarm_relay_nxt;
   reg  [2:0]        forced_terms;

   // hours per setting step, chosen by the unit input
   assign warn_unit  = warning_time_unit_100h ? `DSO_WARN_UNIT_LARGE : `DSO_WARN_UNIT_SMALL;
   // threshold in hours; a 24-bit product covers 6553 x 100 without overflow
   assign warn_hours = {10'h000, warning_time_setting} * warn_unit;
   assign warn_enabled  = (warning_time_setting != `DSO_WARN_DISABLED);
   assign run_hours_ext = {{(24-HOUR_W){1'b0}}, run_hours};
   assign pon_hours_ext = {{(24-HOUR_W){1'b0}}, power_on_hours};

   // strictly greater: status rises only once the time is exceeded
   assign run_over_nxt = warn_enabled && (run_hours_ext > warn_hours);
   assign pon_over_nxt = warn_enabled && (pon_hours_ext > warn_hours);

   // zero speed source follows the control curve; open loop and sensorless use output frequency
   always @* begin
      case (control_curve_select)
         `DSO_CC_SENSOR_VECTOR: zs_source = motor_speed;
         default:               zs_source = output_freq;
      endcase
   end
   // plain compare, no hysteresis, so chatter near the level is possible
   assign zs_nxt = (zs_source < zero_speed_level);

   // quadrant as {reverse, regen}
   assign quadrant = {torque_reverse, torque_regen};

   // quadrant picks the threshold
   always @* begin
      case (quadrant)
         2'h0:    torque_thresh = torque_limit_fwd_drive;
         2'h1:    torque_thresh = torque_limit_fwd_regen;
         2'h2:    torque_thresh = torque_limit_rev_drive;
         2'h3:    torque_thresh = torque_limit_rev_regen;
         default: torque_thresh = torque_limit_fwd_drive;
      endcase
   end

   // torque estimate is only trustworthy in vector modes; flag held low elsewhere
   always @* begin
      case (control_curve_select)
         `DSO_CC_SLV,
         `DSO_CC_SLV_ZERO_RANGE,
         `DSO_CC_SENSOR_VECTOR: vector_mode = 1'b1;
         default:               vector_mode = 1'b0;
      endcase
   end
   assign otq_nxt = vector_mode && (torque_est > torque_thresh);

   // four-bit trip code; unlisted causes land on 15 so a trip never reads normal
   always @* begin
      code4 = `DSO_TC_USER;
      if (trip_cause == `DSO_E_NONE) begin
         code4 = `DSO_TC_NORMAL;
      end else if (trip_cause >= `DSO_E_OC_FIRST && trip_cause <= `DSO_E_OC_LAST) begin
         code4 = `DSO_TC_OVERCURRENT;
      end else if (trip_cause >= `DSO_E_SEQ_FIRST && trip_cause <= `DSO_E_SEQ_LAST) begin
         code4 = `DSO_TC_SEQUENCE;
      end else if (trip_cause >= `DSO_E_USER_FIRST && trip_cause <= `DSO_E_USER_LAST) begin
         code4 = `DSO_TC_USER;
      end else begin
         case (trip_cause)
            `DSO_E_OVERLOAD,
            `DSO_E_LOW_SPD_OVL:  code4 = `DSO_TC_OVERLOAD;
            `DSO_E_OVERVOLT,
            `DSO_E_IN_OVERVOLT:  code4 = `DSO_TC_OVERVOLT;
            `DSO_E_UNDERVOLT:    code4 = `DSO_TC_UNDERVOLT;
            `DSO_E_POWER_FAIL:   code4 = `DSO_TC_POWER_FAIL;
            `DSO_E_POWER_SWITCH: code4 = `DSO_TC_POWER_SWITCH;
            `DSO_E_BRK_RES_OVL:  code4 = `DSO_TC_OTHER_OR_BRKRES;
            `DSO_E_MEMORY,
            `DSO_E_CPU,
            `DSO_E_INT_COMM,
            `DSO_E_MAIN_CIRCUIT: code4 = `DSO_TC_INTERNAL;
            `DSO_E_CT:           code4 = `DSO_TC_CT;
            `DSO_E_EXT_TRIP,
            `DSO_E_USP,
            `DSO_E_THERMISTOR,
            `DSO_E_BRAKING:      code4 = `DSO_TC_EXTERNAL;
            `DSO_E_GROUND:       code4 = `DSO_TC_GROUND;
            `DSO_E_FAN_TEMP_A,
            `DSO_E_FAN_TEMP_B:   code4 = `DSO_TC_FAN_TEMP;
            `DSO_E_PHASE_LOSS:   code4 = `DSO_TC_PHASE_LOSS;
            default:             code4 = `DSO_TC_USER;
         endcase
      end
   end

   // three-bit code folds everything above 6 onto 7
   always @* begin
      case (code4)
         `DSO_TC_NORMAL,
         `DSO_TC_OVERCURRENT,
         `DSO_TC_OVERLOAD,
         `DSO_TC_OVERVOLT,
         `DSO_TC_UNDERVOLT,
         `DSO_TC_POWER_FAIL,
         `DSO_TC_POWER_SWITCH: code3 = code4;
         default:              code3 = `DSO_TC_OTHER_OR_BRKRES;
      endcase
   end

   // mode selects code width; reserved mode values behave as no output
   always @* begin
      trip_code_nxt = `DSO_TC_NORMAL;
      forced_terms  = 3'h0;
      case (trip_code_mode)
         `DSO_TCM_3BIT: begin
            trip_code_nxt = code3;
            forced_terms  = `DSO_CODE_TERMS_3BIT;
         end
         `DSO_TCM_4BIT: begin
            trip_code_nxt = code4;
            forced_terms  = `DSO_CODE_TERMS_4BIT;
         end
         default: begin
            trip_code_nxt = `DSO_TC_NORMAL;
            forced_terms  = 3'h0;
         end
      endcase
   end

   // per-terminal function decode from the freshly computed statuses
   genvar gi;
   generate
      for (gi = 0; gi < N_TERM; gi = gi + 1) begin : g_term
         wire [5:0] fsel;
         reg        sel_level;
         assign fsel = output_terminal_function_select[6*gi +: 6];
         // unknown function codes leave the terminal off
         always @* begin
            case (fsel)
               `DSO_FN_OVER_TORQUE:     sel_level = otq_nxt;
               `DSO_FN_RUN_TIME_OVER:   sel_level = run_over_nxt;
               `DSO_FN_POWER_TIME_OVER: sel_level = pon_over_nxt;
               `DSO_FN_ZERO_SPEED:      sel_level = zs_nxt;
               default:                 sel_level = 1'b0;
            endcase
         end
         // code terminals override selections, terminal 11 carries the lsb
         if (gi < `DSO_CODE_TERMS_4BIT) begin : g_code
            assign terminal_nxt[gi] = (gi < forced_terms) ? trip_code_nxt[gi] : sel_level;
         end else begin : g_plain
            // beyond the widest code, selections always apply
            assign terminal_nxt[gi] = sel_level;
         end
      end
   endgenerate

   // relay supports the time-over and zero-speed functions only
   always @* begin
      case (alarm_relay_function_select)
         `DSO_FN_RUN_TIME_OVER:   alarm_relay_nxt = run_over_nxt;
         `DSO_FN_POWER_TIME_OVER: alarm_relay_nxt = pon_over_nxt;
         `DSO_FN_ZERO_SPEED:      alarm_relay_nxt = zs_nxt;
         default:                 alarm_relay_nxt = 1'b0;
      endcase
   end

   // all outputs registered, one cycle behind their inputs; time-over first
   always @(posedge core_clk) begin
      if (!reset_n) begin
         run_time_over      <= 1'b0;
         power_on_time_over <= 1'b0;
      end else begin
         run_time_over      <= run_over_nxt;
         power_on_time_over <= pon_over_nxt;
      end
   end

   // zero-speed status, live level with no hold time
   always @(posedge core_clk) begin
      if (!reset_n) begin
         zero_speed_detect <= 1'b0;
      end else begin
         zero_speed_detect <= zs_nxt;
      end
   end

   // over-torque status, low outside vector modes
   always @(posedge core_clk) begin
      if (!reset_n) begin
         over_torque_flag <= 1'b0;
      end else begin
         over_torque_flag <= otq_nxt;
      end
   end

   // raw trip code, normal while in reset
   always @(posedge core_clk) begin
      if (!reset_n) begin
         trip_code <= `DSO_TC_NORMAL;
      end else begin
         trip_code <= trip_code_nxt;
      end
   end

   // terminal levels; forced code and selection already merged per bit
   always @(posedge core_clk) begin
      if (!reset_n) begin
         terminal_out <= {N_TERM{1'b0}};
      end else begin
         terminal_out <= terminal_nxt;
      end
   end

   // relay level
   always @(posedge core_clk) begin
      if (!reset_n) begin
         alarm_relay_out <= 1'b0;
      end else begin
         alarm_relay_out <= alarm_relay_nxt;
      end
   end

   // code bits mirror the registered code for observers of the raw code
   assign trip_code_bit0 = trip_code[0];
   assign trip_code_bit1 = trip_code[1];
   assign trip_code_bit2 = trip_code[2];
   assign trip_code_bit3 = trip_code[3];

endmodule // dso_status_out

/* hdl/dso_status_consts.vh */
`ifndef DSO_STATUS_CONSTS_VH
`define DSO_STATUS_CONSTS_VH

// output terminal function selection codes
`define DSO_FN_OVER_TORQUE      6'h07
`define DSO_FN_RUN_TIME_OVER    6'h0B
`define DSO_FN_POWER_TIME_OVER  6'h0C
`define DSO_FN_ZERO_SPEED       6'h15

// trip code mode settings
`define DSO_TCM_NONE            2'h0
`define DSO_TCM_3BIT            2'h1
`define DSO_TCM_4BIT            2'h2

// control curve selection codes
`define DSO_CC_CONST_TORQUE     3'h0
`define DSO_CC_REDUCED_TORQUE   3'h1
`define DSO_CC_FREE_VF          3'h2
`define DSO_CC_SLV              3'h3
`define DSO_CC_SLV_ZERO_RANGE   3'h4
`define DSO_CC_SENSOR_VECTOR    3'h5

// warning time scaling, hours per unit
`define DSO_WARN_UNIT_SMALL     24'h00_000A
`define DSO_WARN_UNIT_LARGE     24'h00_0064
`define DSO_WARN_DISABLED       14'h0000

// trip cause numbers (error index, 0 is no trip)
`define DSO_E_NONE              7'h00
`define DSO_E_OC_FIRST          7'h01
`define DSO_E_OC_LAST           7'h04
`define DSO_E_OVERLOAD          7'h05
`define DSO_E_BRK_RES_OVL       7'h06
`define DSO_E_OVERVOLT          7'h07
`define DSO_E_MEMORY            7'h08
`define DSO_E_UNDERVOLT         7'h09
`define DSO_E_CT                7'h0A
`define DSO_E_CPU               7'h0B
`define DSO_E_EXT_TRIP          7'h0C
`define DSO_E_USP               7'h0D
`define DSO_E_GROUND            7'h0E
`define DSO_E_IN_OVERVOLT       7'h0F
`define DSO_E_POWER_FAIL        7'h10
`define DSO_E_FAN_TEMP_A        7'h14
`define DSO_E_FAN_TEMP_B        7'h15
`define DSO_E_INT_COMM          7'h17
`define DSO_E_PHASE_LOSS        7'h18
`define DSO_E_MAIN_CIRCUIT      7'h19
`define DSO_E_POWER_SWITCH      7'h1E
`define DSO_E_THERMISTOR        7'h23
`define DSO_E_BRAKING           7'h24
`define DSO_E_LOW_SPD_OVL       7'h26
`define DSO_E_SEQ_FIRST         7'h2B
`define DSO_E_SEQ_LAST          7'h2D
`define DSO_E_USER_FIRST        7'h32
`define DSO_E_USER_LAST         7'h4F

// trip codes presented on the terminals
`define DSO_TC_NORMAL           4'h0
`define DSO_TC_OVERCURRENT      4'h1
`define DSO_TC_OVERLOAD         4'h2
`define DSO_TC_OVERVOLT         4'h3
`define DSO_TC_UNDERVOLT        4'h4
`define DSO_TC_POWER_FAIL       4'h5
`define DSO_TC_POWER_SWITCH     4'h6
`define DSO_TC_OTHER_OR_BRKRES  4'h7
`define DSO_TC_INTERNAL         4'h8
`define DSO_TC_CT               4'h9
`define DSO_TC_EXTERNAL         4'hA
`define DSO_TC_GROUND           4'hB
`define DSO_TC_SEQUENCE         4'hC
`define DSO_TC_FAN_TEMP         4'hD
`define DSO_TC_PHASE_LOSS       4'hE
`define DSO_TC_USER             4'hF

// number of terminals forced in each code mode
`define DSO_CODE_TERMS_3BIT     3'h3
`define DSO_CODE_TERMS_4BIT     3'h4

`endif

/* tb/dso_status_out_monitor.sv */
`timescale 1ns/10ps
// port-level checker; every status lags its inputs by one edge
module dso_status_monitor #(
   parameter HOUR_W = 20,
   parameter FREQ_W = 16,
   parameter TORQ_W = 8,
   parameter N_TERM = 5
) (
   input wire logic              core_clk, reset_n, warning_time_unit_100h, torque_reverse, torque_regen,
   input wire logic [HOUR_W-1:0] run_hours, power_on_hours,
   input wire logic [13:0]       warning_time_setting,
   input wire logic [2:0]        control_curve_select,
   input wire logic [FREQ_W-1:0] output_freq, motor_speed, zero_speed_level,
   input wire logic [TORQ_W-1:0] torque_est, torque_limit_fwd_drive, torque_limit_rev_regen,
   input wire logic [TORQ_W-1:0] torque_limit_rev_drive, torque_limit_fwd_regen,
   input wire logic [1:0]        trip_code_mode,
   input wire logic [6:0]        trip_cause,
   input wire logic [5:0]        alarm_relay_function_select,
   input wire logic              run_time_over, power_on_time_over, zero_speed_detect, over_torque_flag,
   input wire logic [3:0]        trip_code,
   input wire logic [N_TERM-1:0] terminal_out,
   input wire logic              alarm_relay_out
);
   logic [TORQ_W-1:0] thr;
   // sensor vector mode watches measured speed, the rest output frequency
   wire [FREQ_W-1:0] mon_f = (control_curve_select == 3'h5) ? motor_speed : output_freq;
   wire [23:0]       lim   = {10'h000, warning_time_setting} * (warning_time_unit_100h ? 24'h00_0064 : 24'h00_000A);
   wire              vec   = (control_curve_select >= 3'h3) && (control_curve_select <= 3'h5);
   // threshold by quadrant {reverse, regen}
   always_comb begin
      case ({torque_reverse, torque_regen})
         2'b00:   thr = torque_limit_fwd_drive;
         2'b11:   thr = torque_limit_rev_regen;
         2'b10:   thr = torque_limit_rev_drive;
         default: thr = torque_limit_fwd_regen;
      endcase
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_zero_speed_cmp: assert property (
      $past(reset_n) |-> zero_speed_detect == $past(mon_f < zero_speed_level)) else $error("zero speed wrong");
   a_over_torque: assert property (
      $past(reset_n) |-> over_torque_flag == $past(vec && (torque_est > thr))) else $error("over torque wrong");
   a_run_time: assert property (
      $past(reset_n) |-> run_time_over == $past(|warning_time_setting && run_hours > lim)) else $error("run time wrong");
   a_power_time: assert property (
      $past(reset_n) |-> power_on_time_over == $past(|warning_time_setting && power_on_hours > lim))
      else $error("power time wrong");
   a_code_four: assert property (
      $past(reset_n && trip_code_mode == 2'h2) |-> terminal_out[3:0] == trip_code) else $error("4-bit terminals wrong");
   a_code_three: assert property (
      $past(reset_n && trip_code_mode == 2'h1) |-> trip_code <= 4'h7 && terminal_out[2:0] == trip_code[2:0])
      else $error("3-bit terminals wrong");
   a_code_normal: assert property (
      $past(reset_n && trip_cause == 7'h00 && (trip_code_mode == 2'h1 || trip_code_mode == 2'h2)) |-> trip_code == 4'h0)
      else $error("normal code wrong");
   a_relay_zero: assert property (
      $past(reset_n && alarm_relay_function_select == 6'h15) |-> alarm_relay_out == zero_speed_detect)
      else $error("relay zero speed wrong");
endmodule // dso_status_monitor
bind dso_status_out dso_status_monitor #(.HOUR_W(HOUR_W), .FREQ_W(FREQ_W), .TORQ_W(TORQ_W), .N_TERM(N_TERM))
   u_dso_status_monitor (.*);

/* tb/dso_ctrl_model.sv */
`timescale 1ns/10ps
// far-side controller reading the over-torque terminal
module dso_ctrl_model (
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic otq_in,
   output logic      brake_stop_r
);
   // latched so a brief torque dip cannot reapply the brake mid-lift
   always @(posedge core_clk) begin
      if (!reset_n)
         brake_stop_r <= 1'b0;
      else if (otq_in)
         brake_stop_r <= 1'b1;
   end
endmodule // dso_ctrl_model

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic        core_clk, reset_n, warning_time_unit_100h, torque_reverse, torque_regen, brake_stop_r;
   logic [19:0] run_hours, power_on_hours;
   logic [13:0] warning_time_setting;
   logic [2:0]  control_curve_select;
   logic [15:0] output_freq, motor_speed, zero_speed_level;
   logic [7:0]  torque_est, torque_limit_fwd_drive, torque_limit_rev_regen, torque_limit_rev_drive, torque_limit_fwd_regen;
   logic [1:0]  trip_code_mode;
   logic [6:0]  trip_cause;
   logic [29:0] output_terminal_function_select;
   logic [5:0]  alarm_relay_function_select;
   logic        run_time_over, power_on_time_over, zero_speed_detect, over_torque_flag, alarm_relay_out;
   logic        trip_code_bit0, trip_code_bit1, trip_code_bit2, trip_code_bit3;
   logic [3:0]  trip_code;
   logic [4:0]  terminal_out;
   int          n_fail, compares;
   // trip causes and their four-bit codes
   logic [6:0]  cs [20] = '{7'h00, 7'h02, 7'h05, 7'h26, 7'h07, 7'h0F, 7'h09, 7'h10, 7'h1E, 7'h06,
                           7'h08, 7'h19, 7'h0A, 7'h0C, 7'h23, 7'h0E, 7'h2C, 7'h14, 7'h18, 7'h4F};
   logic [3:0]  ec [20] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                           4'h8, 4'h8, 4'h9, 4'hA, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
   logic [7:0]  thr_t [4] = '{8'h0A, 8'hC8, 8'h1E, 8'h14};
   logic [13:0] ws [5] = '{14'h0000, 14'h0005, 14'h0005, 14'h03E8, 14'h03E8};
   logic        un [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   logic [19:0] hs [5] = '{20'hF_FFFF, 20'h0_0032, 20'h0_0033, 20'h1_86A0, 20'h1_86A1};

   dso_status_out u_dso_status_out (.*);
   dso_ctrl_model u_dso_ctrl_model (.core_clk(core_clk), .reset_n(reset_n), .otq_in(terminal_out[0]),
                                    .brake_stop_r(brake_stop_r));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // inputs move 1 ns after an edge; results read 1 ns after the next
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   task close_out;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // straddle the level; the unused speed source points the other way except when both sit on the level
   task t_zero_speed;
      for (int i = 0; i < 6; i++) begin
         control_curve_select = (i < 3) ? 3'h0 : 3'h5;
         output_freq = (i < 3) ? 16'h270F + 16'(i % 3) : 16'h2711 - 16'(i % 3);
         motor_speed = (i < 3) ? 16'h2711 - 16'(i % 3) : 16'h270F + 16'(i % 3);
         tick;
         chk({7'h00, zero_speed_detect}, {7'h00, i % 3 == 0});
         chk({2'h0, terminal_out, alarm_relay_out}, (i % 3 == 0) ? 8'h3F : 8'h00);
      end
   endtask
   // each quadrant at and one above its threshold, across all vector modes
   task t_torque;
      output_terminal_function_select = {24'h00_0000, 6'h07};
      for (int q = 0; q < 8; q++) begin
         {torque_reverse, torque_regen} = 2'(q / 2);
         control_curve_select = 3'h3 + 3'(q % 3);
         torque_est = thr_t[q / 2] + 8'(q % 2);
         tick;
         chk({7'h00, over_torque_flag}, {7'h00, q % 2 == 1});
         chk({3'h0, terminal_out}, {7'h00, q % 2 == 1});
      end
      control_curve_select = 3'h2;
      tick;
      chk({7'h00, over_torque_flag}, 8'h00);
   endtask
   // disabled, 10 h and 100 h units, at and just past the limit
   task t_time;
      logic e;
      output_terminal_function_select = {18'h0_0000, 6'h0C, 6'h0B};
      alarm_relay_function_select = 6'h0B;
      for (int i = 0; i < 10; i++) begin
         warning_time_setting = ws[i / 2];
         warning_time_unit_100h = un[i / 2];
         run_hours = (i % 2 == 0) ? hs[i / 2] : 20'h0_0000;
         power_on_hours = (i % 2 == 1) ? hs[i / 2] : 20'h0_0000;
         tick;
         e = (i / 2 == 2) || (i / 2 == 4);
         chk({5'h00, run_time_over, power_on_time_over, alarm_relay_out},
             {5'h00, e && i % 2 == 0, e && i % 2 == 1, e && i % 2 == 0});
         chk({6'h00, terminal_out[1:0]}, {6'h00, e && i % 2 == 1, e && i % 2 == 0});
      end
      alarm_relay_function_select = 6'h15;
   endtask
   // every code in every mode; unforced terminals show zero speed high
   task t_trip;
      logic [3:0] e;
      output_terminal_function_select = {5{6'h15}};
      output_freq = 16'h0000;
      control_curve_select = 3'h0;
      for (int m = 0; m < 4; m++) begin
         trip_code_mode = 2'(m ^ 2);
         for (int i = 0; i < 20; i++) begin
            trip_cause = cs[i];
            tick;
            e = (trip_code_mode == 2'h1 && ec[i] > 4'h7) ? 4'h7 : ec[i];
            if (trip_code_mode == 2'h2) begin
               chk({4'h0, trip_code}, {4'h0, e});
               chk({4'h0, trip_code_bit3, trip_code_bit2, trip_code_bit1, trip_code_bit0}, {4'h0, e});
               chk({3'h0, terminal_out}, {4'h1, e});
            end else if (trip_code_mode == 2'h1) begin
               chk({4'h0, trip_code}, {4'h0, e});
               chk({3'h0, terminal_out}, {5'h03, e[2:0]});
            end else begin
               chk({3'h0, terminal_out}, 8'h1F);
               chk({4'h0, trip_code}, 8'h00);
            end
         end
      end
   endtask
   // second reset in mid-run clears both sides; over-torque then latches the brake stop
   task t_reset;
      trip_code_mode = 2'h0;
      output_terminal_function_select = {{4{6'h15}}, 6'h07};
      control_curve_select = 3'h3;
      {torque_reverse, torque_regen} = 2'h0;
      torque_est = 8'h0A;
      reset_n = 1'b0;
      tick;
      chk({3'h0, terminal_out}, 8'h00);
      chk({7'h00, brake_stop_r}, 8'h00);
      reset_n = 1'b1;
      tick;
      chk({3'h0, terminal_out}, 8'h1E);
      torque_est = 8'h0B;
      tick;
      chk({3'h0, terminal_out}, 8'h1F);
      chk({7'h00, brake_stop_r}, 8'h00);
      tick;
      chk({7'h00, brake_stop_r}, 8'h01);
   endtask

   initial begin
      n_fail = 0;
      compares = 0;
      reset_n = 1'b0;
      {torque_reverse, torque_regen, warning_time_unit_100h} = 3'h0;
      {run_hours, power_on_hours} = 40'h00_0000_0000;
      warning_time_setting = 14'h0000;
      control_curve_select = 3'h0;
      {output_freq, motor_speed} = 32'h0000_0000;
      zero_speed_level = 16'h2710;
      torque_est = 8'h00;
      {torque_limit_fwd_drive, torque_limit_fwd_regen, torque_limit_rev_drive, torque_limit_rev_regen} = 32'h0AC8_1E14;
      trip_code_mode = 2'h0;
      trip_cause = 7'h00;
      output_terminal_function_select = {5{6'h15}};
      alarm_relay_function_select = 6'h15;
      repeat (5) @(posedge core_clk);
      #1 reset_n = 1'b1;
      t_zero_speed;
      t_torque;
      t_time;
      t_trip;
      t_reset;
      close_out;
   end
endmodule // tb_top
